/* design/frame_interval_consts.vh */
`ifndef FRAME_INTERVAL_CONSTS_VH
`define FRAME_INTERVAL_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define OSC_DIVIDE 125
`define TICK_CNT_W 7
`define TICK_LAST 7'h7C

// ****************************************
// Random generator
// ****************************************
`define RAND_W 7
`define RAND_RESET 7'h40
`define RAND_TAPS 7'h44
`define INIT_RAND_MULT 6'h28

// ****************************************
// Field widths
// ****************************************
`define BASE_W 8
`define FRAME_TIME_W 6
`define FRAME_COUNT_W 4
`define DELAY_W 13

`endif

/* design/interval_random_gen.v */
`timescale 1ns/100ps
`include "frame_interval_consts.vh"

module interval_random_gen (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Control
    input wire i_advance,
    // Random value
    output wire [`RAND_W-1:0] o_value
);

    reg [`RAND_W-1:0] state_reg;
    wire [`RAND_W-1:0] state_next;

    // ****************************************
    // Galois shift, primitive x^7+x^3+1
    // ****************************************
    assign state_next = state_reg[0] ?
        ((state_reg >> 1) ^ `RAND_TAPS) : (state_reg >> 1);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= `RAND_RESET;
        end else if (i_advance) begin
            state_reg <= state_next;
        end
    end

    assign o_value = state_reg;

endmodule

/* design/rf_frame_interval_generator.v */
// Functional notes
// - 8-bit base down-counter, initial and interframe
// - Zero base setting gives no base delay
// - Random delay only with nonzero seed field
// - Initial spacing enable: forty times random
// - Seven-stage Galois shift register, primitive polynomial
// - Cycles through 127 nonzero values
// - Shift register starts at hex 40
// - Sample when needed, advance after use
// - Seed field only; state not readable
// - Random interval 1..127 ms on tick
// - Zero state stays zero; never seed zero
// - Frame delay between frames, times frame number
// - Count setting plus one frames sent
// - Six-bit frame time multiple on tick
// - Runs in deepest stop when enabled
// - Interframe delay with random is sum of parts
// - No random: base and frame concurrent, max
// - Expiry starts sending without processor
`timescale 1ns/100ps
`include "frame_interval_consts.vh"

module rf_frame_interval_generator (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Oscillator and power
    input wire i_medium_freq_oscillator,
    input wire i_transmitter_enable,
    input wire i_deepest_stop_mode,
    // Settings
    input wire [`BASE_W-1:0] i_base_time_setting,
    input wire [`RAND_W-1:0] i_random_seed_field,
    input wire i_initial_spacing_enable,
    input wire [`FRAME_TIME_W-1:0] i_frame_time_setting,
    input wire [`FRAME_COUNT_W-1:0] i_frame_count_setting,
    // Frame sequencer
    input wire i_start,
    input wire i_frame_sent,
    output wire o_busy,
    output reg o_interval_done,
    output reg o_send_frame,
    output reg o_datagram_done,
    output reg [`FRAME_COUNT_W-1:0] o_frame_number,
    // Seed readback
    output wire [`RAND_W-1:0] o_random_seed_readback
);

    localparam ST_IDLE = 2'h0;
    localparam ST_COUNT = 2'h1;
    localparam ST_SEND = 2'h2;

    reg rst_sync1_reg;
    reg rst_sync2_reg;
    wire rst_n;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`TICK_CNT_W-1:0] div_reg;
    reg tick_reg;
    reg [`BASE_W-1:0] base_reg;
    reg [`DELAY_W-1:0] rand_reg;
    reg [`DELAY_W-1:0] fn_reg;
    reg [`FRAME_COUNT_W-1:0] frames_reg;
    reg first_reg;
    reg adv_reg;
    wire running;
    wire [`RAND_W-1:0] rand_value;
    wire rand_on;
    wire [`DELAY_W-1:0] rand_load;
    wire [`DELAY_W-1:0] rand_x40;
    wire [`DELAY_W-1:0] fn_load;
    wire all_zero;
    wire last_frame;

    // ****************************************
    // Reset release
    // ****************************************
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    assign rst_n = rst_sync2_reg;

    // Keeps running in deepest stop while enabled
    assign running = i_transmitter_enable;

    // ****************************************
    // Millisecond tick from oscillator
    // ****************************************
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= {`TICK_CNT_W{1'b0}};
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (!running) begin
                div_reg <= {`TICK_CNT_W{1'b0}};
            end else if (i_medium_freq_oscillator) begin
                if (div_reg == `TICK_LAST) begin
                    div_reg <= {`TICK_CNT_W{1'b0}};
                    tick_reg <= 1'b1;
                end else begin
                    div_reg <= div_reg + 7'h01;
                end
            end
        end
    end

    // ****************************************
    // Random generator
    // ****************************************
    interval_random_gen u_rand (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_advance(adv_reg),
        .o_value(rand_value)
    );

    // Seed readback only, running state hidden
    assign o_random_seed_readback = i_random_seed_field;

    assign rand_on = (i_random_seed_field != {`RAND_W{1'b0}});
    assign rand_x40 = {6'h00, rand_value} * {7'h00, `INIT_RAND_MULT};
    assign rand_load = !rand_on ? {`DELAY_W{1'b0}} :
        ((first_reg && i_initial_spacing_enable) ?
        rand_x40 : {6'h00, rand_value});
    assign fn_load = {7'h00, i_frame_time_setting} * {9'h000, frames_reg + 4'h1};
    assign last_frame = (frames_reg == i_frame_count_setting);
    assign all_zero = (base_reg == {`BASE_W{1'b0}}) &&
        (rand_reg == {`DELAY_W{1'b0}}) && (fn_reg == {`DELAY_W{1'b0}});

    // ****************************************
    // Sequencing
    // ****************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_start && running) begin
                    state_next = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!running) begin
                    state_next = ST_IDLE;
                end else if (all_zero) begin
                    state_next = ST_SEND;
                end
            end
            ST_SEND: begin
                if (!running || (i_frame_sent && last_frame)) begin
                    state_next = ST_IDLE;
                end else if (i_frame_sent) begin
                    state_next = ST_COUNT;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            base_reg <= {`BASE_W{1'b0}};
            rand_reg <= {`DELAY_W{1'b0}};
            fn_reg <= {`DELAY_W{1'b0}};
            frames_reg <= {`FRAME_COUNT_W{1'b0}};
            first_reg <= 1'b0;
            adv_reg <= 1'b0;
            o_interval_done <= 1'b0;
            o_send_frame <= 1'b0;
            o_datagram_done <= 1'b0;
            o_frame_number <= {`FRAME_COUNT_W{1'b0}};
        end else begin
            state_reg <= state_next;
            adv_reg <= 1'b0;
            o_interval_done <= 1'b0;
            o_send_frame <= 1'b0;
            o_datagram_done <= 1'b0;
            if (state_reg == ST_IDLE && state_next == ST_COUNT) begin
                // Initial interval: base plus random, no frame term
                base_reg <= i_base_time_setting;
                first_reg <= 1'b1;
                frames_reg <= {`FRAME_COUNT_W{1'b0}};
                rand_reg <= {`DELAY_W{1'b0}};
                fn_reg <= {`DELAY_W{1'b0}};
            end else if (state_reg == ST_SEND && state_next == ST_COUNT) begin
                base_reg <= i_base_time_setting;
                fn_reg <= fn_load;
                frames_reg <= frames_reg + 4'h1;
            end else if (state_reg == ST_COUNT) begin
                if (all_zero) begin
                    o_interval_done <= 1'b1;
                    o_send_frame <= 1'b1;
                    first_reg <= 1'b0;
                    adv_reg <= rand_on;
                end else if (tick_reg) begin
                    // With no random both counters run together
                    if (base_reg != {`BASE_W{1'b0}}) begin
                        base_reg <= base_reg - 8'h01;
                    end
                    if (fn_reg != {`DELAY_W{1'b0}} && base_reg == {`BASE_W{1'b0}}) begin
                        fn_reg <= fn_reg - 13'h0001;
                    end else if (fn_reg != {`DELAY_W{1'b0}} && !rand_on) begin
                        fn_reg <= fn_reg - 13'h0001;
                    end
                    if (rand_reg != {`DELAY_W{1'b0}} && base_reg == {`BASE_W{1'b0}}
                            && fn_reg == {`DELAY_W{1'b0}}) begin
                        rand_reg <= rand_reg - 13'h0001;
                    end
                end
            end
            if (state_reg != ST_COUNT && state_next == ST_COUNT) begin
                rand_reg <= (state_reg == ST_IDLE && i_initial_spacing_enable && rand_on) ?
                    rand_x40 : rand_load;
                if (state_reg == ST_IDLE) begin
                    first_reg <= 1'b1;
                end
            end
            if (state_reg == ST_SEND && state_next == ST_IDLE && running) begin
                o_datagram_done <= 1'b1;
            end
            if (state_next == ST_SEND && state_reg == ST_COUNT) begin
                o_frame_number <= frames_reg;
            end
        end
    end

    assign o_busy = (state_reg == ST_COUNT);

endmodule

/* sim/rf_frame_interval_generator_sva.sv */
`timescale 1ns/100ps
module rf_frame_interval_generator_sva (
    // Clock, reset, settings
    input wire i_clk,
    input wire i_resetn,
    input wire i_transmitter_enable,
    input wire [7:0] i_base_time_setting,
    input wire [6:0] i_random_seed_field,
    input wire [3:0] i_frame_count_setting,
    input wire i_start,
    // Outputs
    input wire o_busy,
    input wire o_interval_done,
    input wire o_send_frame,
    input wire o_datagram_done,
    input wire [3:0] o_frame_number,
    input wire [6:0] o_random_seed_readback
);
    reg [1:0] up_cnt;
    wire up = up_cnt == 2'h3;
    wire go = up && i_start && !o_busy && !o_send_frame && i_transmitter_enable;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            up_cnt <= 2'h0;
        else if (!up)
            up_cnt <= up_cnt + 2'h1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    AST_DONE_PULSE: assert property (o_interval_done |=> !o_interval_done)
        else $error("done pulse too long");
    AST_DGRAM_PULSE: assert property (o_datagram_done |=> !o_datagram_done)
        else $error("datagram pulse too long");
    AST_SEND_PAIR: assert property (o_interval_done == o_send_frame)
        else $error("send not with done");
    AST_READBACK: assert property (up |-> o_random_seed_readback == i_random_seed_field)
        else $error("readback not seed");
    AST_ZERO_FAST: assert property (go && i_base_time_setting == 8'h00 &&
        i_random_seed_field == 7'h00 |-> ##2 o_interval_done) else $error("zero delay slow");
    AST_BASE_WAIT: assert property (go && i_base_time_setting != 8'h00 |=>
        !o_interval_done [*8]) else $error("base delay skipped");
    AST_FNUM_RANGE: assert property (o_interval_done |-> o_frame_number <= i_frame_count_setting)
        else $error("frame number range");
    AST_DONE_ENABLED: assert property (o_interval_done |-> $past(i_transmitter_enable))
        else $error("done while disabled");
    cover property (o_datagram_done);
    cover property (o_interval_done && o_frame_number == 4'h2);
    cover property ($fell(i_transmitter_enable) && o_busy);
endmodule
bind rf_frame_interval_generator rf_frame_interval_generator_sva sva (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_transmitter_enable(i_transmitter_enable),
    .i_base_time_setting(i_base_time_setting), .i_random_seed_field(i_random_seed_field),
    .i_frame_count_setting(i_frame_count_setting), .i_start(i_start), .o_busy(o_busy),
    .o_interval_done(o_interval_done), .o_send_frame(o_send_frame),
    .o_datagram_done(o_datagram_done), .o_frame_number(o_frame_number),
    .o_random_seed_readback(o_random_seed_readback));

/* sim/frame_sequencer_model.sv */
`timescale 1ns/100ps
module frame_sequencer_model (
    // Clock and handshake
    input wire i_clk,
    input wire i_send_frame,
    input wire [7:0] i_delay,
    output reg o_frame_sent
);
    reg [7:0] wait_cnt;
    reg active;
    initial begin
        o_frame_sent = 1'b0;
        active = 1'b0;
        wait_cnt = 8'h00;
    end
    always @(posedge i_clk) begin
        o_frame_sent <= 1'b0;
        if (i_send_frame) begin
            active <= 1'b1;
            wait_cnt <= i_delay;
        end else if (active && wait_cnt == 8'h00) begin
            active <= 1'b0;
            o_frame_sent <= 1'b1;
        end else if (active)
            wait_cnt <= wait_cnt - 8'h01;
    end
endmodule

/* sim/rf_frame_interval_generator_tb_top.sv */
`timescale 1ns/100ps
module rf_frame_interval_generator_tb_top;
    reg i_clk, i_resetn, en, stop, isp, start, osc, half;
    reg [7:0] base, dly;
    reg [6:0] seed;
    reg [5:0] ftime;
    integer err_count, tests_run, cyc, wd, k, ticks, per_ms;
    wire busy, done, send, dgram, sent;
    wire [3:0] fnum;
    wire [6:0] rb;
    reg [3:0] fcnt;
    rf_frame_interval_generator uut (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_medium_freq_oscillator(osc), .i_transmitter_enable(en), .i_deepest_stop_mode(stop),
        .i_base_time_setting(base), .i_random_seed_field(seed), .i_initial_spacing_enable(isp),
        .i_frame_time_setting(ftime), .i_frame_count_setting(fcnt), .i_start(start),
        .i_frame_sent(sent), .o_busy(busy), .o_interval_done(done), .o_send_frame(send),
        .o_datagram_done(dgram), .o_frame_number(fnum), .o_random_seed_readback(rb));
    frame_sequencer_model seq (.i_clk(i_clk), .i_send_frame(send), .i_delay(dly),
        .o_frame_sent(sent));
    // ****************************************
    // Tasks
    // ****************************************
    task finish_test;
        begin
            $display("checks %0d errors %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task check_eq(input [31:0] seen, input [31:0] exp, input [8*10:1] name);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("mismatch %0s exp %0h seen %0h", name, exp, seen);
            end
        end
    endtask
    task step;
        begin
            @(posedge i_clk);
            #1;
        end
    endtask
    task do_reset;
        begin
            i_resetn = 1'b0;
            repeat (2) step;
            i_resetn = 1'b1;
            repeat (3) step;
        end
    endtask
    task measure(input integer s, input integer e, input integer f);
        begin
            while (s && sent !== 1'b1) step;
            cyc = 0;
            while (done !== 1'b1 && cyc < 20000) begin
                step;
                cyc = cyc + 1;
            end
            if (e >= 0)
                check_eq(cyc > (e - 1) * per_ms && cyc <= e * per_ms + 8, 1, "delay");
            check_eq(fnum, f, "fnum");
            step;
        end
    endtask
    task datagram(input [3:0] c, input integer e0, input integer e1, input integer e2);
        begin
            fcnt = c;
            start = 1'b1;
            step;
            start = 1'b0;
            measure(0, e0, 0);
            for (k = 1; k <= c; k = k + 1)
                measure(1, (k == 1) ? e1 : e2, k);
            wd = 0;
            while (dgram !== 1'b1 && wd < 100) begin
                step;
                wd = wd + 1;
            end
            check_eq(dgram, 1, "dgram");
        end
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Oscillator strobe: every cycle, or every second cycle when half is set
    always @(posedge i_clk) begin
        #1 osc = half ? ~osc : 1'b1;
    end
    always @(posedge i_clk) begin
        ticks = ticks + 1;
        if (ticks == 60000) begin
            err_count = err_count + 1;
            finish_test;
        end
    end
    initial begin
        {en, stop, isp, start, base, dly, seed, ftime, fcnt} = 0;
        {osc, half} = 2'b00;
        per_ms = 125;
        en = 1'b1;
        dly = 8'h03;
        ticks = 0;
        err_count = 0;
        tests_run = 0;
        do_reset;
        check_eq({busy, done, send, dgram}, 0, "idle");
        datagram(4'h0, 0, 0, 0);
        base = 8'h05;
        datagram(4'h2, 5, 5, 5);
        ftime = 6'h03;
        stop = 1'b1;
        dly = 8'h14;
        half = 1'b1;
        per_ms = 250;
        datagram(4'h2, 5, 5, 6);
        half = 1'b0;
        per_ms = 125;
        {ftime, stop, base} = 0;
        seed = 7'h15;
        dly = 8'h01;
        check_eq(rb, 7'h15, "readback");
        datagram(4'h1, 64, 32, 0);
        check_eq(cyc <= 127 * 125 + 8 && (cyc <= 63 * 125 || cyc > 64 * 125 + 8), 1, "rand2");
        do_reset;
        isp = 1'b1;
        fcnt = 4'h0;
        start = 1'b1;
        step;
        start = 1'b0;
        repeat (8750) step;
        check_eq(busy, 1, "spacing");
        en = 1'b0;
        repeat (3) step;
        check_eq({busy, done}, 0, "abort");
        finish_test;
    end
endmodule
